// ===== logic/dmr_pkg.sv
// shared constants and types for the request-pin activation channel
package dmr_pkg;

  // default widths of the data path and of the transfer counters
  localparam int DMR_DATA_W  = 16;
  localparam int DMR_COUNT_W = 16;

  // values after reset
  localparam logic DMR_RST_ENABLE = 1'b0;  // channel disabled
  localparam logic DMR_RST_END_N  = 1'b1;  // end strobe idle high
  localparam logic DMR_RST_ARMED  = 1'b0;  // no request accepted

  // channel sequencing states
  typedef enum logic [1:0] {
    DMR_ST_IDLE = 2'b00,  // enabled or not, waiting for a request
    DMR_ST_MOVE = 2'b01,  // bus owned, units moving
    DMR_ST_FREE = 2'b10   // bus handed back for one cycle
  } dmr_state_t;

endpackage

// ===== logic/dmr_buf2.sv
// two-entry buffer with registered ready and valid on both sides
module dmr_buf2 import dmr_pkg::*; #(
  parameter int W = DMR_DATA_W
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // filling side
  input  wire logic         in_allow,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // draining side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  // whole buffer state
  typedef struct packed {
    logic [1:0]   count;   // words held
    logic [W-1:0] e0;      // head word
    logic [W-1:0] e1;      // second word
    logic         rdy;     // ready toward the filler
    logic         vld;     // valid toward the drainer
  } dmr_buf_t;

  dmr_buf_t s;       // registered state
  dmr_buf_t next_s;  // next state

  logic push;  // word taken in
  logic pop;   // word handed out

  // shifting storage keeps the head in e0 so the output is a flop
  always_comb begin
    next_s = s;
    push   = in_valid & s.rdy;
    pop    = s.vld & out_ready;
    next_s.count = s.count + {1'b0, push} - {1'b0, pop};
    if (pop && !push) begin
      // head leaves, second word moves up
      next_s.e0 = s.e1;
    end else if (push && !pop) begin
      // new word lands behind what is held
      if (s.count == 2'd0) begin
        next_s.e0 = in_data;
      end else begin
        next_s.e1 = in_data;
      end
    end else if (push && pop) begin
      // one in, one out
      if (s.count == 2'd1) begin
        next_s.e0 = in_data;
      end else begin
        next_s.e0 = s.e1;
        next_s.e1 = in_data;
      end
    end
    // ready is only offered with room left and the owner allowing it
    next_s.rdy = (next_s.count != 2'd2) && in_allow;
    next_s.vld = (next_s.count != 2'd0);
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready  = s.rdy;
  assign out_valid = s.vld;
  assign out_data  = s.e0;

endmodule

// ===== logic/dmr_channel.sv
// one channel activated by the active-low request pin
module dmr_channel import dmr_pkg::*; #(
  parameter int DW = DMR_DATA_W,
  parameter int CW = DMR_COUNT_W
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // software control
  input  wire logic          enable_wr,
  input  wire logic          enable_wdata,
  input  wire logic [CW-1:0] total_count,
  input  wire logic [CW-1:0] block_size,
  input  wire logic          request_enable,
  input  wire logic          edge_mode,
  input  wire logic          single_mode,
  input  wire logic          block_mode,
  input  wire logic          next_request_delay,
  // software status
  output logic               channel_enable_bit,
  output logic               channel_active_bit,
  output logic               request_pending,
  // pins
  input  wire logic          dma_request_n,
  output logic               transfer_end_n,
  output logic               bus_busy,
  // source side of the data path
  input  wire logic          src_valid,
  input  wire logic [DW-1:0] src_data,
  output logic               src_ready,
  // destination side of the data path
  output logic               dst_valid,
  output logic [DW-1:0]      dst_data,
  input  wire logic          dst_ready
);

  // whole channel state
  typedef struct packed {
    dmr_state_t    state;       // sequencing state
    logic          enable;      // channel enable bit
    logic          pending;     // latched transfer request
    logic          armed;       // pin sampling accepts a low
    logic          high_seen;   // edge mode saw the pin high
    logic          rearm_dly;   // level rearm postponed one cycle
    logic          busy;        // bus owned by the channel
    logic          end_n;       // end strobe, low one cycle
    logic [CW-1:0] fetch_left;  // units still to read this request
    logic [CW-1:0] put_left;    // units still to write this request
    logic [CW-1:0] total_left;  // units left in the whole transfer
  } dmr_chan_t;

  dmr_chan_t s;       // registered state
  dmr_chan_t next_s;  // next state

  logic buf_allow;  // buffer may offer ready next cycle
  logic src_hs;     // source word accepted
  logic dst_hs;     // destination word accepted (write done)

  // units moved for one accepted request
  function automatic logic [CW-1:0] units_per_req(
    input logic          single,
    input logic          block,
    input logic [CW-1:0] bsize
  );
    logic [CW-1:0] u;
    u = {{(CW-1){1'b0}}, 1'b1};
    // single address mode always one unit per request
    if (!single && block && (bsize != '0)) begin
      u = bsize;
    end
    return u;
  endfunction

  // count one down, saturating at zero
  function automatic logic [CW-1:0] dec1(input logic [CW-1:0] v);
    return (v == '0) ? v : v - {{(CW-1){1'b0}}, 1'b1};
  endfunction

  assign src_hs = src_valid & src_ready;
  assign dst_hs = dst_valid & dst_ready;

  // next-state logic of the channel
  always_comb begin
    next_s       = s;
    next_s.end_n = 1'b1;

    // software enable write
    if (enable_wr) begin
      if (enable_wdata && !s.enable) begin
        next_s.enable     = 1'b1;
        next_s.armed      = 1'b1;
        next_s.pending    = 1'b0;
        next_s.total_left = total_count;
      end else if (!enable_wdata) begin
        // stop: no new request taken, current one finishes
        next_s.enable  = 1'b0;
        next_s.pending = 1'b0;
        next_s.armed   = 1'b0;
      end
    end

    if (s.enable && s.armed && request_enable && !dma_request_n) begin
      next_s.pending = 1'b1;
    end

    if (s.enable && edge_mode && !s.armed && dma_request_n) begin
      next_s.high_seen = 1'b1;
      // after the cycle ended a late high still rearms
      if (s.state != DMR_ST_MOVE) begin
        next_s.armed = 1'b1;
      end
    end

    case (s.state)
      DMR_ST_IDLE: begin
        if (s.pending && s.enable && !(enable_wr && !enable_wdata)) begin
          next_s.state      = DMR_ST_MOVE;
          next_s.busy       = 1'b1;
          next_s.pending    = 1'b0;
          next_s.armed      = 1'b0;
          next_s.high_seen  = 1'b0;
          next_s.fetch_left = units_per_req(single_mode, block_mode, block_size);
          next_s.put_left   = units_per_req(single_mode, block_mode, block_size);
        end
      end
      DMR_ST_MOVE: begin
        if (src_hs) begin
          next_s.fetch_left = dec1(s.fetch_left);
        end
        if (dst_hs) begin
          next_s.put_left   = dec1(s.put_left);
          next_s.total_left = dec1(s.total_left);
          if (s.put_left == {{(CW-1){1'b0}}, 1'b1}) begin
            next_s.state = DMR_ST_FREE;
            next_s.busy  = 1'b0;
            if (s.total_left == {{(CW-1){1'b0}}, 1'b1}) begin
              next_s.enable  = 1'b0;
              next_s.armed   = 1'b0;
              next_s.pending = 1'b0;
              next_s.end_n   = 1'b0;
            end else if (next_s.enable) begin
              if (edge_mode) begin
                next_s.armed = s.high_seen | dma_request_n;
              end else begin
                next_s.armed     = !next_request_delay;
                next_s.rearm_dly = next_request_delay;
              end
            end
          end
        end
      end
      DMR_ST_FREE: begin
        next_s.state     = DMR_ST_IDLE;
        next_s.rearm_dly = 1'b0;
        if (s.rearm_dly && s.enable) begin
          next_s.armed = 1'b1;
        end
      end
      default: begin
        next_s.state = DMR_ST_IDLE;
        next_s.busy  = 1'b0;
      end
    endcase

    // source reads allowed only while this request still needs words
    buf_allow = (next_s.state == DMR_ST_MOVE) && (next_s.fetch_left != '0);
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      s         <= '0;
      s.state   <= DMR_ST_IDLE;
      s.enable  <= DMR_RST_ENABLE;
      s.armed   <= DMR_RST_ARMED;
      s.end_n   <= DMR_RST_END_N;
    end else begin
      s <= next_s;
    end
  end

  // data path buffer, stalls by the destination back up to the source
  dmr_buf2 #(
    .W (DW)
  ) u_buf (
    .mclk      (mclk),
    .rst       (rst),
    .in_allow  (buf_allow),
    .in_valid  (src_valid),
    .in_data   (src_data),
    .in_ready  (src_ready),
    .out_valid (dst_valid),
    .out_data  (dst_data),
    .out_ready (dst_ready)
  );

  // status outputs straight from state flops
  assign channel_enable_bit = s.enable;
  assign channel_active_bit = s.busy;
  assign request_pending    = s.pending;
  assign transfer_end_n     = s.end_n;
  assign bus_busy           = s.busy;

endmodule

// ===== test/dmr_channel_monitor.sv
// assertions on the request-pin channel ports
module dmr_channel_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic request_enable,
  input wire logic edge_mode,
  input wire logic block_mode,
  input wire logic next_request_delay,
  input wire logic channel_enable_bit,
  input wire logic channel_active_bit,
  input wire logic request_pending,
  input wire logic dma_request_n,
  input wire logic transfer_end_n,
  input wire logic bus_busy,
  input wire logic dst_valid,
  input wire logic dst_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // busy mirrors active, and an idle disabled channel never starts by itself
  property p_busy; (bus_busy == channel_active_bit)
    && (channel_enable_bit || $past(channel_active_bit) || !channel_active_bit); endproperty
  a_busy: assert property (p_busy) else $error("busy differs");
  property p_pend; $rose(request_pending) |->
    $past(channel_enable_bit) && $past(request_enable) && !$past(dma_request_n); endproperty
  a_pend: assert property (p_pend) else $error("bad latch");
  property p_take; $rose(channel_active_bit) |-> !request_pending && $past(request_pending);
  endproperty
  a_take: assert property (p_take) else $error("bad start");
  property p_rel; $fell(channel_active_bit) |-> $past(dst_valid) && $past(dst_ready);
  endproperty
  a_rel: assert property (p_rel) else $error("early release");
  property p_one; channel_active_bit && dst_valid && dst_ready && !block_mode
    |=> !channel_active_bit; endproperty
  a_one: assert property (p_one) else $error("extra unit");
  property p_end; !transfer_end_n |-> !channel_enable_bit && !channel_active_bit
    && $past(channel_active_bit); endproperty
  a_end: assert property (p_end) else $error("bad end");
  property p_pulse; !transfer_end_n |=> transfer_end_n; endproperty
  a_pulse: assert property (p_pulse) else $error("long end");
  property p_nrd; !edge_mode && next_request_delay && $fell(channel_active_bit)
    |-> !request_pending ##1 !request_pending; endproperty
  a_nrd: assert property (p_nrd) else $error("early rearm");
endmodule
bind dmr_channel dmr_channel_monitor u_mon (
  .mclk               (mclk),
  .rst                (rst),
  .request_enable     (request_enable),
  .edge_mode          (edge_mode),
  .block_mode         (block_mode),
  .next_request_delay (next_request_delay),
  .channel_enable_bit (channel_enable_bit),
  .channel_active_bit (channel_active_bit),
  .request_pending    (request_pending),
  .dma_request_n      (dma_request_n),
  .transfer_end_n     (transfer_end_n),
  .bus_busy           (bus_busy),
  .dst_valid          (dst_valid),
  .dst_ready          (dst_ready)
);

// ===== test/dmr_peripheral.sv
// peripheral model driving the request pin
module dmr_peripheral (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic want,
  input  wire logic stay,
  input  wire logic request_pending,
  output logic      dma_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic low_f;  // one request still owed
  always_ff @(posedge mclk) begin
    if (rst) low_f <= 1'b0;
    else if (want) low_f <= 1'b1;
    else if (request_pending) low_f <= 1'b0;
  end
  // stay keeps the pin low for level runs
  assign dma_request_n = ~(low_f | stay);
endmodule

// ===== test/dmr_channel_bench.sv
// self-checking bench for the request-pin channel
module dmr_channel_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // driven inputs
  logic mclk, rst, enable_wr, enable_wdata, request_enable, edge_mode, single_mode;
  logic block_mode, next_request_delay, src_valid, dst_ready, want, stay;
  logic [15:0] total_count, block_size, src_data, exp_d, dst_data, src_cnt;
  // observed outputs
  logic channel_enable_bit, channel_active_bit, request_pending, dma_request_n;
  logic transfer_end_n, bus_busy, src_ready, dst_valid, act_q;
  int fails, total_checks, n_act, n_src, n_end;
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  dmr_peripheral u_per (
    .mclk            (mclk),
    .rst             (rst),
    .want            (want),
    .stay            (stay),
    .request_pending (request_pending),
    .dma_request_n   (dma_request_n)
  );
  dmr_channel dut (
    .mclk               (mclk),
    .rst                (rst),
    .enable_wr          (enable_wr),
    .enable_wdata       (enable_wdata),
    .total_count        (total_count),
    .block_size         (block_size),
    .request_enable     (request_enable),
    .edge_mode          (edge_mode),
    .single_mode        (single_mode),
    .block_mode         (block_mode),
    .next_request_delay (next_request_delay),
    .channel_enable_bit (channel_enable_bit),
    .channel_active_bit (channel_active_bit),
    .request_pending    (request_pending),
    .dma_request_n      (dma_request_n),
    .transfer_end_n     (transfer_end_n),
    .bus_busy           (bus_busy),
    .src_valid          (src_valid),
    .src_data           (src_data),
    .src_ready          (src_ready),
    .dst_valid          (dst_valid),
    .dst_data           (dst_data),
    .dst_ready          (dst_ready)
  );
  // next source word is presented at the falling edge
  always @(negedge mclk) src_data <= src_cnt;
  // tallies events; words leave in order
  always @(posedge mclk) begin
    act_q <= channel_active_bit;
    if (channel_active_bit === 1'b1 && act_q === 1'b0) n_act++;
    if (src_valid && src_ready === 1'b1) n_src++;
    if (src_valid && src_ready === 1'b1) src_cnt <= src_cnt + 16'h0001;
    if (transfer_end_n === 1'b0) n_end++;
    if (dst_valid === 1'b1 && dst_ready) chk(dst_data, exp_d);
    if (dst_valid === 1'b1 && dst_ready) exp_d <= exp_d + 16'h0001;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) fails++;
    if (got !== exp) $display("Error %0t got %h want %h", $time, got, exp);
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // sets modes and writes the enable bit
  task automatic start(input logic e, s, b, d, input logic [15:0] t);
    {edge_mode, single_mode, block_mode, next_request_delay, total_count} = {e, s, b, d, t};
    n_act = 0;
    n_src = 0;
    n_end = 0;
    enable_wr = 1'b1;
    @(negedge mclk);
    enable_wr = 1'b0;
  endtask
  // bounded wait for completion
  task automatic wait_off;
    for (int i = 0; i < 300 && channel_enable_bit !== 1'b0; i++) @(negedge mclk);
    if (channel_enable_bit !== 1'b0) begin
      fails++;
      summarize;
    end else begin
      repeat (2) @(negedge mclk);
    end
  endtask
  task automatic t_idle;
    stay = 1'b1;
    repeat (6) @(negedge mclk);
    chk(16'(request_pending), 16'h0000);
    request_enable = 1'b0;
    start(0, 0, 0, 0, 16'h0001);
    repeat (10) @(negedge mclk);
    chk(16'(request_pending), 16'h0000);
    request_enable = 1'b1;
    wait_off;
    chk(16'(n_act), 16'h0001);
    stay = 1'b0;
  endtask
  task automatic t_level(input logic s, input logic d);
    start(0, s, 0, d, 16'h0003);
    stay = 1'b1;
    wait_off;
    stay = 1'b0;
    chk(16'(n_act), 16'h0003);
    chk(16'(n_src), 16'h0003);
    chk(16'(n_end), 16'h0001);
  endtask
  task automatic t_edge(input logic s);
    start(1, s, 0, 0, 16'h0002);
    stay = 1'b1;
    repeat (40) @(negedge mclk);
    chk(16'(n_act), 16'h0001);
    stay = 1'b0;
    repeat (3) @(negedge mclk);
    want = 1'b1;
    @(negedge mclk);
    want = 1'b0;
    wait_off;
    chk(16'(n_act), 16'h0002);
  endtask
  task automatic t_block;
    dst_ready = 1'b0;
    start(0, 0, 1, 0, 16'h0004);
    stay = 1'b1;
    repeat (30) @(negedge mclk);
    chk(16'(n_src), 16'h0002);
    chk(16'(bus_busy), 16'h0001);
    dst_ready = 1'b1;
    wait_off;
    chk(16'(n_act), 16'h0001);
  endtask
  // stop write ends an endless run
  task automatic t_stop;
    int n;
    start(0, 0, 0, 0, 16'h0000);
    stay = 1'b1;
    repeat (20) @(negedge mclk);
    {enable_wr, enable_wdata} = 2'b10;
    @(negedge mclk);
    {enable_wr, enable_wdata} = 2'b01;
    chk(16'(channel_enable_bit), 16'h0000);
    repeat (10) @(negedge mclk);
    n = n_act;
    repeat (20) @(negedge mclk);
    stay = 1'b0;
    chk(16'(n >= 2), 16'h0001);
    chk(16'(n_act), 16'(n));
    chk(16'(channel_active_bit), 16'h0000);
    chk(16'(n_end), 16'h0000);
  endtask
  initial begin
    {rst, enable_wr, enable_wdata, request_enable} = 4'hb;
    {edge_mode, single_mode, block_mode, next_request_delay, want, stay} = 6'h00;
    {src_valid, dst_ready} = 2'h3;
    {total_count, block_size, src_data, exp_d} = 64'h0000_0004_0000_0000;
    src_cnt = 16'h0000;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    t_idle;
    for (int i = 0; i < 4; i++) t_level(i[0], i[1]);
    t_edge(1'b1);
    t_edge(1'b0);
    t_block;
    t_stop;
    summarize;
  end
  // cuts a hang short
  initial begin
    #100000;
    fails++;
    summarize;
  end
endmodule
